/* File: bench/macrocell_register_init_control_tb_top.sv */
// Self-checking testbench for the macrocell register init control.
`timescale 1ns/1ps
`default_nettype none
module macrocell_register_init_control_tb_top;
	// ----------------------------------------
	// Signals and instance
	// ----------------------------------------
	localparam int PU = 8;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0000_0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [9:0] sum_term = 10'h000;
	logic preset_pin = 1'b0;
	logic reset_pin = 1'b0;
	logic [9:0] out_pin;
	logic [9:0] out_oe;
	logic [9:0] feedback;
	logic [31:0] rd;
	logic err;
	int error_cnt = 0;
	int n_tests = 0;

	always #5 pclk = ~pclk;

	mc_init_ctrl #(.CELLS(10), .PU_CYC(PU)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sum_term(sum_term), .preset_pin(preset_pin),
		.reset_pin(reset_pin), .out_pin(out_pin), .out_oe(out_oe), .feedback(feedback));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask : chk

	// The slave never stretches the access phase (pready is tied high), but the wait is still bounded.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {20'h00000, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) begin
				break;
			end
		end
		if (i == 20) begin
			error_cnt++;
			stop_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
		chk({31'h0, err}, 32'h0000_0000);
	endtask : rd_chk

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : wait_cyc

	// Preload shows on feedback only briefly, since the sum term reloads the flop next edge.
	task automatic preload_seen(input logic [9:0] v, output logic hit);
		hit = 1'b0;
		apb(1'b1, mc_init_pkg::OFS_PRELOAD, {22'h000000, v});
		repeat (5) begin
			@(posedge pclk);
			#1;
			if (feedback === v) begin
				hit = 1'b1;
			end
		end
	endtask : preload_seen

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_power_up;
		int i;
		chk({22'h000000, out_oe}, 32'h0000_0000);
		for (i = 0; i < PU + 10; i++) begin
			apb(1'b0, mc_init_pkg::OFS_STATUS, 32'h0000_0000);
			if (rd[0] === 1'b1) begin
				break;
			end
		end
		chk({31'h0, rd[0]}, 32'h0000_0001);
		rd_chk(mc_init_pkg::OFS_STATE, 32'h0000_0000);
		chk({22'h000000, out_oe}, 32'h0000_03FF);
	endtask : t_power_up

	task automatic t_terms;
		apb(1'b1, mc_init_pkg::OFS_CONFIG, 32'h0000_0155);
		sum_term <= 10'h3FF;
		wait_cyc(4);
		rd_chk(mc_init_pkg::OFS_STATE, 32'h0000_03FF);
		reset_pin <= 1'b1;
		wait_cyc(8);
		rd_chk(mc_init_pkg::OFS_STATE, 32'h0000_0000);
		chk({22'h000000, out_pin}, 32'h0000_02AA);
		reset_pin <= 1'b0;
		sum_term <= 10'h000;
		wait_cyc(8);
		apb(1'b1, mc_init_pkg::OFS_TERMS, 32'h0000_0001);
		wait_cyc(2);
		rd_chk(mc_init_pkg::OFS_STATE, 32'h0000_03FF);
		chk({22'h000000, out_pin}, 32'h0000_0155);
		apb(1'b1, mc_init_pkg::OFS_TERMS, 32'h0000_0003);
		wait_cyc(2);
		rd_chk(mc_init_pkg::OFS_STATE, 32'h0000_0000);
		apb(1'b1, mc_init_pkg::OFS_TERMS, 32'h0000_0000);
		preset_pin <= 1'b1;
		wait_cyc(8);
		rd_chk(mc_init_pkg::OFS_STATE, 32'h0000_03FF);
		preset_pin <= 1'b0;
		wait_cyc(8);
	endtask : t_terms

	// Bypassed cells show the sum term with polarity, and feed back from the pin.
	task automatic t_bypass;
		apb(1'b1, mc_init_pkg::OFS_CONFIG, 32'h03FF_0155);
		sum_term <= 10'h00F;
		wait_cyc(4);
		chk({22'h000000, out_pin}, 32'h0000_02A5);
		chk({22'h000000, feedback}, 32'h0000_02A5);
		rd_chk(mc_init_pkg::OFS_PIN, 32'h0000_02A5);
		sum_term <= 10'h000;
		apb(1'b1, mc_init_pkg::OFS_CONFIG, 32'h0000_0000);
		wait_cyc(4);
	endtask : t_bypass

	task automatic t_secure;
		logic hit;
		preload_seen(10'h2A5, hit);
		chk({31'h0, hit}, 32'h0000_0001);
		apb(1'b1, mc_init_pkg::OFS_RB_ADDR, 32'h0000_0003);
		apb(1'b1, mc_init_pkg::OFS_RB_DATA, 32'h1234_5678);
		rd_chk(mc_init_pkg::OFS_RB_DATA, 32'h1234_5678);
		apb(1'b1, mc_init_pkg::OFS_SECURE, 32'h0000_0001);
		rd_chk(mc_init_pkg::OFS_STATUS, 32'h0000_0003);
		rd_chk(mc_init_pkg::OFS_RB_DATA, 32'hFFFF_FFFF);
		apb(1'b1, mc_init_pkg::OFS_RB_DATA, 32'h0000_0000);
		rd_chk(mc_init_pkg::OFS_RB_DATA, 32'hFFFF_FFFF);
		preload_seen(10'h15A, hit);
		chk({31'h0, hit}, 32'h0000_0000);
		apb(1'b1, mc_init_pkg::OFS_SECURE, 32'h0000_0000);
		apb(1'b1, mc_init_pkg::OFS_ERASE, 32'h0000_0001);
		rd_chk(mc_init_pkg::OFS_STATUS, 32'h0000_0003);
		apb(1'b1, mc_init_pkg::OFS_ERASE, mc_init_pkg::ERASE_KEY);
		rd_chk(mc_init_pkg::OFS_STATUS, 32'h0000_0001);
		rd_chk(mc_init_pkg::OFS_RB_DATA, 32'h0000_0000);
		apb(1'b1, mc_init_pkg::OFS_RB_DATA, 32'h0000_5A5A);
		rd_chk(mc_init_pkg::OFS_RB_DATA, 32'h0000_5A5A);
		preload_seen(10'h0F0, hit);
		chk({31'h0, hit}, 32'h0000_0001);
	endtask : t_secure

	task automatic t_unmapped;
		apb(1'b1, 12'h0FC, 32'hA5A5_A5A5);
		chk({31'h0, err}, 32'h0000_0001);
		apb(1'b0, 12'h0FC, 32'h0000_0000);
		chk({31'h0, err}, 32'h0000_0001);
		chk(rd, 32'h0000_0000);
	endtask : t_unmapped

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		t_power_up();
		t_terms();
		t_bypass();
		t_secure();
		t_unmapped();
		stop_test();
	end
endmodule : macrocell_register_init_control_tb_top
`default_nettype wire

/* File: rtl/mc_cell_ff.sv */
// One macrocell output flip-flop with global preset, reset and preload.
`timescale 1ns/1ps
`default_nettype none
module mc_cell_ff (
	input wire logic pclk,
	input wire logic clear_n,
	input wire mc_init_pkg::terms_t terms,
	input wire logic d,
	input wire logic preload_en,
	input wire logic preload_val,
	input wire logic polarity_select_bit,
	output logic q,
	output logic pin
);
	wire logic arst_n;
	// Asynchronous reset beats preset because it bypasses the clock.
	assign arst_n = clear_n & ~terms.async_reset_term;
	always_ff @(posedge pclk or negedge arst_n) begin // [R2] [R13] [R15]
		if (!arst_n) begin
			q <= 1'b0;
		end else if (preload_en) begin
			q <= preload_val; // [R7]
		end else if (terms.sync_preset_term) begin
			q <= 1'b1; // [R1]
		end else begin
			q <= d;
		end
	end
	assign pin = polarity_select_bit ? q : ~q; // [R4] [R14]
endmodule : mc_cell_ff
`default_nettype wire

/* File: rtl/mc_init_ctrl.sv */
// Top of the macrocell register init control with APB register access.
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
//Contract
// R1: Preset term sets flops high on edge.
// R2: Reset term clears flops low immediately.
// R3: One preset and reset shared by cells.
// R4: Terms act on flop; pin follows polarity.
// R5: Power-up forces every flop low.
// R6: Power-up clearing finishes within bounded delay.
// R7: Any state loadable into registers for test.
// R8: Security bit blocks pattern readback.
// R9: Secured readback returns all programmed.
// R10: Secured device ignores register preload.
// R11: Security clears only with full erase; here presetn also clears it.
// R12: Programmer erases automatically during programming; here the pattern is erased only by writing ERASE_KEY to OFS_ERASE.
// R13: Flops capture on rising clock edge.
// R14: Polarity one active high, zero inverted.
// R15: Async reset wins over sync preset.
module mc_init_ctrl #(
	parameter int CELLS = mc_init_pkg::NUM_CELLS,
	parameter int PU_CYC = mc_init_pkg::PU_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [CELLS-1:0] sum_term,
	input wire logic preset_pin,
	input wire logic reset_pin,
	output logic [CELLS-1:0] out_pin,
	output logic [CELLS-1:0] out_oe,
	output logic [CELLS-1:0] feedback
);
	// ----------------------------------------
	// Parameter checks
	// ----------------------------------------
	initial begin
		if (CELLS < 1 || CELLS > 16) begin
			$error("CELLS must lie in 1 to 16");
		end
		if (PU_CYC < 1 || PU_CYC >= (1 << mc_init_pkg::PU_CW)) begin
			$error("PU_CYC out of counter range");
		end
	end

	logic [CELLS-1:0] polarity_select_bit;
	logic [CELLS-1:0] register_bypass_select_bit;
	logic sw_preset;
	logic sw_reset;
	logic [CELLS-1:0] preload_data;
	logic preload_pulse;
	logic secure;
	logic [mc_init_pkg::ARRAY_AW-1:0] rb_addr;
	logic [31:0] pattern [0:15];
	logic [mc_init_pkg::PU_CW-1:0] pu_cnt;
	mc_init_pkg::pu_state_t pu_state;
	logic pu_done;
	logic [2:0] pre_sync;
	logic [2:0] rst_sync;
	logic pre_clean;
	logic rst_clean;
	mc_init_pkg::terms_t terms;
	logic [CELLS-1:0] q;
	logic [CELLS-1:0] pin_level;
	logic wr;
	logic rd;
	logic [11:0] a;
	logic addr_ok;

	function automatic logic hit(input logic [11:0] x, input logic [11:0] o);
		hit = (x == o);
	endfunction : hit

	assign wr = psel & penable & pwrite;
	assign rd = psel & penable & ~pwrite;
	assign a = paddr[11:0];
	assign pready = 1'b1;
	assign addr_ok = (paddr[31:12] == 20'h00000) && (a[1:0] == 2'b00) &&
		(a <= mc_init_pkg::OFS_STATUS);
	assign pslverr = psel & penable & ~addr_ok;

	// ----------------------------------------
	// Power-up clearing
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin // [R5] [R6]
		if (!presetn) begin
			pu_state <= mc_init_pkg::PU_CLEAR;
			pu_cnt <= '0;
		end else begin
			case (pu_state)
				mc_init_pkg::PU_CLEAR: begin
					if (pu_cnt == mc_init_pkg::PU_CW'(PU_CYC - 1)) begin
						pu_state <= mc_init_pkg::PU_RUN;
					end else begin
						pu_cnt <= pu_cnt + 1'b1;
					end
				end
				mc_init_pkg::PU_RUN: begin
					pu_cnt <= pu_cnt;
				end
				default: begin
					pu_state <= mc_init_pkg::PU_CLEAR;
				end
			endcase
		end
	end
	assign pu_done = (pu_state == mc_init_pkg::PU_RUN);

	// ----------------------------------------
	// Pin term synchronisers
	// ----------------------------------------
	// Pin terms come from outside; a change counts once stages two and three agree.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_sync <= 3'h0;
			rst_sync <= 3'h0;
			pre_clean <= 1'b0;
			rst_clean <= 1'b0;
		end else begin
			pre_sync <= {pre_sync[1:0], preset_pin};
			rst_sync <= {rst_sync[1:0], reset_pin};
			if (pre_sync[1] == pre_sync[2]) begin
				pre_clean <= pre_sync[2];
			end
			if (rst_sync[1] == rst_sync[2]) begin
				rst_clean <= rst_sync[2];
			end
		end
	end
	// The reset term drives async clears, so it comes straight from a flop, never from gates.
	logic rst_term;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_term <= 1'b0;
		end else begin
			rst_term <= rst_clean | (wr & hit(a, mc_init_pkg::OFS_TERMS) &
				pwdata[mc_init_pkg::TERM_RESET_BIT]) | (sw_reset & ~(wr & hit(a,
				mc_init_pkg::OFS_TERMS)));
		end
	end
	assign terms.async_reset_term = rst_term;
	assign terms.sync_preset_term = pre_clean | sw_preset;

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			polarity_select_bit <= '0;
			register_bypass_select_bit <= '0;
		end else if (wr && hit(a, mc_init_pkg::OFS_CONFIG)) begin
			polarity_select_bit <= pwdata[mc_init_pkg::POL_LSB +: CELLS];
			register_bypass_select_bit <= pwdata[mc_init_pkg::BYP_LSB +: CELLS];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_preset <= 1'b0;
			sw_reset <= 1'b0;
		end else if (wr && hit(a, mc_init_pkg::OFS_TERMS)) begin
			sw_preset <= pwdata[mc_init_pkg::TERM_PRESET_BIT];
			sw_reset <= pwdata[mc_init_pkg::TERM_RESET_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			preload_data <= '0;
			preload_pulse <= 1'b0;
		end else begin
			preload_pulse <= wr & hit(a, mc_init_pkg::OFS_PRELOAD) & ~secure; // [R10]
			if (wr && hit(a, mc_init_pkg::OFS_PRELOAD) && !secure) begin // [R7]
				preload_data <= pwdata[CELLS-1:0];
			end
		end
	end

	// Security can only be set by software; only the whole-pattern erase or presetn clears it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			secure <= 1'b0;
		end else if (wr && hit(a, mc_init_pkg::OFS_SECURE) && pwdata[0]) begin
			secure <= 1'b1;
		end else if (wr && hit(a, mc_init_pkg::OFS_ERASE) && pwdata == mc_init_pkg::ERASE_KEY) begin
			secure <= 1'b0; // [R11]
		end
	end

	// The pattern store is small; its erase doubles as the security clear.
	always_ff @(posedge pclk) begin
		for (int i = 0; i < 16; i++) begin
			if (wr && hit(a, mc_init_pkg::OFS_ERASE) && pwdata == mc_init_pkg::ERASE_KEY) begin
				pattern[i] <= 32'h0000_0000; // [R11]
			end else if (wr && hit(a, mc_init_pkg::OFS_RB_DATA) && !secure &&
				rb_addr[3:0] == 4'(i)) begin
				pattern[i] <= pwdata;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rb_addr <= '0;
		end else if (wr && hit(a, mc_init_pkg::OFS_RB_ADDR)) begin
			rb_addr <= pwdata[mc_init_pkg::ARRAY_AW-1:0];
		end
	end

	// ----------------------------------------
	// Macrocells
	// ----------------------------------------
	for (genvar c = 0; c < CELLS; c++) begin : g_cell
		mc_cell_ff u_ff ( // [R3]
			.pclk(pclk),
			.clear_n(presetn & pu_done),
			.terms(terms),
			.d(sum_term[c]),
			.preload_en(preload_pulse),
			.preload_val(preload_data[c]),
			.polarity_select_bit(polarity_select_bit[c]),
			.q(q[c]),
			.pin(pin_level[c])
		);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_pin <= '0;
			feedback <= '0;
		end else begin
			for (int c = 0; c < CELLS; c++) begin
				out_pin[c] <= register_bypass_select_bit[c] ?
					(polarity_select_bit[c] ? sum_term[c] : ~sum_term[c]) : pin_level[c]; // [R14]
				feedback[c] <= register_bypass_select_bit[c] ? out_pin[c] : q[c];
			end
		end
	end
	assign out_oe = {CELLS{pu_done}};

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= 32'h0000_0000;
			case (a)
				mc_init_pkg::OFS_CONFIG: begin
					prdata[mc_init_pkg::POL_LSB +: CELLS] <= polarity_select_bit;
					prdata[mc_init_pkg::BYP_LSB +: CELLS] <= register_bypass_select_bit;
				end
				mc_init_pkg::OFS_TERMS: prdata[1:0] <= {sw_reset, sw_preset};
				mc_init_pkg::OFS_PRELOAD: prdata[CELLS-1:0] <= preload_data;
				mc_init_pkg::OFS_STATE: prdata[CELLS-1:0] <= q;
				mc_init_pkg::OFS_PIN: prdata[CELLS-1:0] <= out_pin;
				mc_init_pkg::OFS_SECURE: prdata[0] <= secure;
				mc_init_pkg::OFS_RB_ADDR: prdata[mc_init_pkg::ARRAY_AW-1:0] <= rb_addr;
				mc_init_pkg::OFS_RB_DATA: begin
					prdata <= secure ? mc_init_pkg::RB_SECURED_WORD : pattern[rb_addr[3:0]]; // [R8] [R9]
				end
				mc_init_pkg::OFS_STATUS: begin
					prdata[mc_init_pkg::ST_PU_DONE_BIT] <= pu_done;
					prdata[mc_init_pkg::ST_SECURE_BIT] <= secure;
				end
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_preset_only;
		terms.sync_preset_term && !terms.async_reset_term && !preload_pulse && pu_done;
	endsequence
	property p_preset;
		@(posedge pclk) disable iff (!presetn) s_preset_only ##1 !terms.async_reset_term |-> &q;
	endproperty
	a_preset: assert property (p_preset) else $error("preset did not set flops"); // [R1]
	property p_reset;
		@(posedge pclk) disable iff (!presetn) terms.async_reset_term |-> q == '0;
	endproperty
	a_reset: assert property (p_reset) else $error("reset did not clear flops"); // [R2]
	property p_powerup;
		@(posedge pclk) disable iff (!presetn) !pu_done |-> q == '0;
	endproperty
	a_powerup: assert property (p_powerup) else $error("flops not low at power-up"); // [R5]
	property p_pu_bound;
		@(posedge pclk) disable iff (!presetn) $rose(presetn) || pu_cnt == '0 |-> ##[0:1000] pu_done;
	endproperty
	a_pu_bound: assert property (p_pu_bound) else $error("power-up clear too long"); // [R6]
	property p_secure_rb;
		@(posedge pclk) disable iff (!presetn)
			psel && !penable && !pwrite && hit(a, mc_init_pkg::OFS_RB_DATA) && secure
			|=> prdata == mc_init_pkg::RB_SECURED_WORD;
	endproperty
	a_secure_rb: assert property (p_secure_rb) else $error("secured readback leaked"); // [R9]
	property p_no_preload;
		@(posedge pclk) disable iff (!presetn) secure |=> !preload_pulse;
	endproperty
	a_no_preload: assert property (p_no_preload) else $error("preload while secured"); // [R10]
	property p_secure_hold;
		@(posedge pclk) disable iff (!presetn)
			secure && !(wr && hit(a, mc_init_pkg::OFS_ERASE)) |=> secure;
	endproperty
	a_secure_hold: assert property (p_secure_hold) else $error("security bit lost"); // [R11]
	property p_polarity;
		@(posedge pclk) disable iff (!presetn)
			!register_bypass_select_bit[0] && $stable(polarity_select_bit[0])
			|=> out_pin[0] == ($past(polarity_select_bit[0]) ? $past(q[0]) : ~$past(q[0]));
	endproperty
	a_polarity: assert property (p_polarity) else $error("pin polarity wrong"); // [R14]
endmodule : mc_init_ctrl
`default_nettype wire

/* File: rtl/mc_init_pkg.sv */
// Package with constants, register map and carrier types of the macrocell init control.
package mc_init_pkg;
	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NUM_CELLS = 10;
	localparam int PU_DELAY_US = 10;
	localparam int CLK_MHZ = 100;
	localparam int PU_CYCLES = PU_DELAY_US * CLK_MHZ;
	localparam int PU_CW = 11;
	localparam int ARRAY_AW = 12;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [11:0] OFS_CONFIG = 12'h000;
	localparam logic [11:0] OFS_TERMS = 12'h004;
	localparam logic [11:0] OFS_PRELOAD = 12'h008;
	localparam logic [11:0] OFS_STATE = 12'h00C;
	localparam logic [11:0] OFS_PIN = 12'h010;
	localparam logic [11:0] OFS_SECURE = 12'h014;
	localparam logic [11:0] OFS_ERASE = 12'h018;
	localparam logic [11:0] OFS_RB_ADDR = 12'h01C;
	localparam logic [11:0] OFS_RB_DATA = 12'h020;
	localparam logic [11:0] OFS_STATUS = 12'h024;
	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int POL_LSB = 0;
	localparam int BYP_LSB = 16;
	localparam int TERM_PRESET_BIT = 0;
	localparam int TERM_RESET_BIT = 1;
	localparam int ST_PU_DONE_BIT = 0;
	localparam int ST_SECURE_BIT = 1;
	localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
	localparam logic [31:0] RB_SECURED_WORD = 32'hFFFF_FFFF;
	localparam logic [31:0] ERASE_KEY = 32'h0000_0E5E;

	typedef struct packed {
		logic sync_preset_term;
		logic async_reset_term;
	} terms_t;

	typedef enum logic [1:0] {
		PU_CLEAR = 2'b00,
		PU_RUN = 2'b01
	} pu_state_t;
endpackage : mc_init_pkg
